// ### sru_pkg.sv
// package for the segment register unit: encodings, layouts and carriers
`default_nettype none
package sru_pkg;
	localparam int          SRU_SEL_W        = 16;
	localparam int          SRU_VA_W         = 64;
	localparam int          SRU_CANON_BIT    = 47;
	localparam logic [31:0] SRU_MSR_AUX_ONE  = 32'hC0000100;
	localparam logic [31:0] SRU_MSR_AUX_TWO  = 32'hC0000101;
	localparam logic [2:0]  SRU_SEG_EXTRA    = 3'h0;
	localparam logic [2:0]  SRU_SEG_CODE     = 3'h1;
	localparam logic [2:0]  SRU_SEG_STACK    = 3'h2;
	localparam logic [2:0]  SRU_SEG_DATA     = 3'h3;
	localparam logic [2:0]  SRU_SEG_AUX_ONE  = 3'h4;
	localparam logic [2:0]  SRU_SEG_AUX_TWO  = 3'h5;
	localparam int          SRU_NUM_SEG      = 6;
	localparam int          SRU_IDX_LSB      = 3;
	localparam int          SRU_TSEL_BIT     = 2;
	localparam logic [15:0] SRU_SEL_RESET    = 16'h0000;
	localparam logic [63:0] SRU_BASE_RESET   = 64'h0000000000000000;
	localparam logic [31:0] SRU_LIMIT_RESET  = 32'h0000FFFF;
	localparam logic [1:0]  SRU_PRIV_RESET   = 2'h0;

	// kind of reference the core makes
	typedef enum logic [1:0] {SRU_REF_FETCH, SRU_REF_DATA, SRU_REF_STRING_DST, SRU_REF_STACK} sru_ref_e;

	// decoded selector fields
	typedef struct packed {
		logic [12:0] index;
		logic        table_select_bit;
		logic [1:0]  requester_privilege;
	} sru_selector_s;

	// descriptor copy as delivered from the table walker
	typedef struct packed {
		logic [63:0] base;
		logic [31:0] limit;
		logic [1:0]  descriptor_privilege;
		logic        wide_mode;
		logic        op_size;
		logic        present;
	} sru_desc_s;

	// one segment register: visible selector plus hidden copy
	typedef struct packed {
		logic [15:0] selector;
		sru_desc_s   hidden;
	} sru_seg_s;

	// reference request from the address pipeline
	typedef struct packed {
		logic        valid;
		sru_ref_e    kind;
		logic        override_en;
		logic [2:0]  override_seg;
		logic [63:0] base_reg;
		logic [63:0] index_reg;
		logic [1:0]  scale_log2;
		logic [63:0] displacement;
	} sru_ref_s;

	// reference result
	typedef struct packed {
		logic        valid;
		logic [63:0] effective_addr;
		logic [63:0] linear_addr;
		logic [2:0]  segment;
		logic        protection_fault;
	} sru_res_s;

	// canonical form: bits above the top implemented bit copy it
	function automatic logic sru_is_canonical(input logic [63:0] va);
		sru_is_canonical = (va[63:SRU_CANON_BIT] == '0) || (va[63:SRU_CANON_BIT] == '1);
	endfunction : sru_is_canonical
endpackage : sru_pkg
`default_nettype wire

// ### sru_addr_gen.sv
// effective address adder with segment base and limit or canonical checks
`default_nettype none
module sru_addr_gen (
	// inputs
	input  wire logic [63:0] base_reg,
	input  wire logic [63:0] index_reg,
	input  wire logic [1:0]  scale_log2,
	input  wire logic [63:0] displacement,
	input  wire logic [63:0] seg_base,
	input  wire logic [31:0] seg_limit,
	input  wire logic        long_64,
	input  wire logic        use_base,
	// outputs
	output var  logic [63:0] effective_addr,
	output var  logic [63:0] linear_addr,
	output var  logic        range_fault
);
	import sru_pkg::*;

	// wrap is intended: sums fold across positive and negative addresses
	always_comb begin
		effective_addr = base_reg + (index_reg << scale_log2) + displacement;
		if (long_64) begin
			linear_addr = use_base ? seg_base + effective_addr : effective_addr;
			range_fault = !sru_is_canonical(linear_addr);
		end else begin
			// legacy width: only the low doubleword of base and offset counts
			linear_addr = {32'h00000000, seg_base[31:0] + effective_addr[31:0]};
			range_fault = (effective_addr[31:0] > seg_limit);
		end
	end
endmodule : sru_addr_gen
`default_nettype wire

// ### sru_top.sv
// segment register unit: six selectors with hidden copies and address forming
`default_nettype none
// How it works
// - six segment registers each with a 16-bit selector
// - selection codes extra 0 code 1 stack 2 data 3 aux 4 and 5
// - loading a selector copies the given descriptor into the hidden copy
// - hidden copies not software visible except the two auxiliary bases
// - code loads set current privilege to descriptor privilege
// - fetches always use the code segment
// - data uses default data; string destinations extra; stack ops stack
// - in 64-bit mode code base is zero and canonical check replaces limit
// - in 64-bit mode extra, data and stack have base zero, canonical checks
// - mode changes leave all segment registers untouched
// - auxiliary override address is 64-bit base plus offset, wrapping
// - auxiliary overrides in 64-bit mode only check canonical form
// - selector load into auxiliary writes 32-bit base, upper bits cleared
// - null selector into auxiliary keeps hidden copy unchanged
// - auxiliary bases as model registers, 64-bit write at privilege zero
// - enabled user base writes in 64-bit mode, 32-bit operand zero-extends
// - non-canonical base write raises protection fault, base unchanged
// - compatibility mode ignores upper 32 auxiliary base bits
// - selector index bits 15 to 3, table bit 2, privilege bits 1 to 0
// - outside 64-bit mode reference through null selector faults
module sru_top (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// mode
	input  wire logic                 long_64,
	input  wire logic                 user_base_write_enable,
	// segment load from the descriptor fetch path
	input  wire logic                 load_valid,
	input  wire logic [2:0]           load_seg,
	input  wire logic [15:0]          load_selector,
	input  wire sru_pkg::sru_desc_s   load_desc,
	// model register write
	input  wire logic                 model_reg_write_insn,
	input  wire logic [31:0]          model_reg_addr,
	input  wire logic [63:0]          model_reg_data,
	// user base write instructions
	input  wire logic                 write_aux_one_base_insn,
	input  wire logic                 write_aux_two_base_insn,
	input  wire logic                 base_op_32,
	input  wire logic [63:0]          base_wr_data,
	// model register read and selector read
	input  wire logic                 model_reg_read_insn,
	input  wire logic [2:0]           sel_read_seg,
	// address reference
	input  wire sru_pkg::sru_ref_s    ref_req,
	// outputs
	output var  sru_pkg::sru_res_s    ref_res,
	output var  logic [1:0]           current_privilege,
	output var  logic                 wide_mode,
	output var  logic                 op_size,
	output var  logic                 base_write_fault,
	output var  logic                 base_write_done,
	output var  logic [63:0]          model_reg_rdata,
	output var  logic                 model_reg_rvalid,
	output var  logic [15:0]          sel_read_data
);
	import sru_pkg::*;

	// whole state of the unit
	typedef struct packed {
		sru_seg_s [SRU_NUM_SEG-1:0] seg;
		logic [1:0]                 current_privilege;
		sru_res_s                   res;
		logic                       base_write_fault;
		logic                       base_write_done;
		logic [63:0]                model_reg_rdata;
		logic                       model_reg_rvalid;
		logic [15:0]                sel_read_data;
	} sru_state_s;

	sru_state_s  st;
	sru_state_s  next_st;
	logic [2:0]  use_seg;
	sru_seg_s    use_entry;
	logic        use_base;
	logic [63:0] ag_ea;
	logic [63:0] ag_lin;
	logic        ag_fault;

	// true when the selector is the null one: index zero and global table
	function automatic logic sru_is_null(input logic [15:0] sel);
		sru_selector_s s;
		s = sel;
		sru_is_null = (s.index == '0) && !s.table_select_bit;
	endfunction : sru_is_null

	// pick segment for a reference
	always_comb begin
		use_seg = SRU_SEG_DATA;
		case (ref_req.kind)
			SRU_REF_FETCH:      use_seg = SRU_SEG_CODE;
			SRU_REF_STRING_DST: use_seg = SRU_SEG_EXTRA;
			SRU_REF_STACK:      use_seg = SRU_SEG_STACK;
			SRU_REF_DATA: begin
				if (ref_req.override_en && ref_req.override_seg < 3'(SRU_NUM_SEG))
					use_seg = ref_req.override_seg;
			end
			default:            use_seg = SRU_SEG_DATA;
		endcase
		use_entry = st.seg[use_seg];
		// in 64-bit mode only the auxiliary segments carry a base
		use_base  = !long_64 || use_seg == SRU_SEG_AUX_ONE || use_seg == SRU_SEG_AUX_TWO;
	end

	sru_addr_gen u_addr_gen (
		.base_reg       (ref_req.base_reg),
		.index_reg      (ref_req.index_reg),
		.scale_log2     (ref_req.scale_log2),
		.displacement   (ref_req.displacement),
		.seg_base       (use_entry.hidden.base),
		.seg_limit      (use_entry.hidden.limit),
		.long_64        (long_64),
		.use_base       (use_base),
		.effective_addr (ag_ea),
		.linear_addr    (ag_lin),
		.range_fault    (ag_fault)
	);

	// next-state logic: loads, base writes, reads and reference results
	always_comb begin
		logic        aux_sel;
		logic [2:0]  aux_idx;
		logic [63:0] wdata;
		logic        wr_any;
		aux_sel = 1'b0;
		aux_idx = SRU_SEG_AUX_ONE;
		wdata   = '0;
		wr_any  = 1'b0;
		next_st = st;
		next_st.base_write_fault = 1'b0;
		next_st.base_write_done  = 1'b0;
		next_st.model_reg_rvalid = 1'b0;

		// mode inputs never touch the stored registers; only loads and base writes do
		if (load_valid && load_seg < 3'(SRU_NUM_SEG)) begin
			aux_sel = (load_seg == SRU_SEG_AUX_ONE) || (load_seg == SRU_SEG_AUX_TWO);
			next_st.seg[load_seg].selector = load_selector;
			if (aux_sel) begin
				// null into an auxiliary keeps the hidden copy
				if (!sru_is_null(load_selector)) begin
					next_st.seg[load_seg].hidden = load_desc;
					next_st.seg[load_seg].hidden.base = {32'h00000000, load_desc.base[31:0]};
				end
			end else begin
				next_st.seg[load_seg].hidden = load_desc;
			end
			if (load_seg == SRU_SEG_CODE)
				next_st.current_privilege = load_desc.descriptor_privilege;
		end

		// base writes: privileged model register path, or enabled user path
		if (model_reg_write_insn && st.current_privilege == 2'h0 &&
		    (model_reg_addr == SRU_MSR_AUX_ONE || model_reg_addr == SRU_MSR_AUX_TWO)) begin
			wr_any  = 1'b1;
			aux_idx = (model_reg_addr == SRU_MSR_AUX_ONE) ? SRU_SEG_AUX_ONE : SRU_SEG_AUX_TWO;
			wdata   = model_reg_data;
		end else if ((write_aux_one_base_insn || write_aux_two_base_insn) &&
		             user_base_write_enable && long_64) begin
			wr_any  = 1'b1;
			aux_idx = write_aux_one_base_insn ? SRU_SEG_AUX_ONE : SRU_SEG_AUX_TWO;
			wdata   = base_op_32 ? {32'h00000000, base_wr_data[31:0]} : base_wr_data;
		end
		if (wr_any) begin
			if (sru_is_canonical(wdata)) begin
				next_st.seg[aux_idx].hidden.base = wdata;
				next_st.base_write_done = 1'b1;
			end else begin
				next_st.base_write_fault = 1'b1;
			end
		end

		// only the auxiliary bases are readable from the hidden side
		if (model_reg_read_insn && st.current_privilege == 2'h0) begin
			next_st.model_reg_rvalid = 1'b1;
			if (model_reg_addr == SRU_MSR_AUX_ONE)
				next_st.model_reg_rdata = st.seg[SRU_SEG_AUX_ONE].hidden.base;
			else if (model_reg_addr == SRU_MSR_AUX_TWO)
				next_st.model_reg_rdata = st.seg[SRU_SEG_AUX_TWO].hidden.base;
			else
				next_st.model_reg_rdata = '0;
		end
		next_st.sel_read_data = (sel_read_seg < 3'(SRU_NUM_SEG)) ? st.seg[sel_read_seg].selector : '0;

		// reference result, one cycle after the request
		next_st.res.valid          = ref_req.valid;
		next_st.res.effective_addr = ag_ea;
		next_st.res.linear_addr    = ag_lin;
		next_st.res.segment        = use_seg;
		next_st.res.protection_fault = ref_req.valid &&
			(ag_fault || (!long_64 && sru_is_null(use_entry.selector)));
	end

	// register the state; software owns code and stack loads before use
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			for (int i = 0; i < SRU_NUM_SEG; i++) begin
				st.seg[i].selector                    <= SRU_SEL_RESET;
				st.seg[i].hidden.base                 <= SRU_BASE_RESET;
				st.seg[i].hidden.limit                <= SRU_LIMIT_RESET;
				st.seg[i].hidden.descriptor_privilege <= SRU_PRIV_RESET;
				st.seg[i].hidden.wide_mode            <= 1'b0;
				st.seg[i].hidden.op_size              <= 1'b0;
				st.seg[i].hidden.present              <= 1'b1;
			end
			st.current_privilege <= SRU_PRIV_RESET;
			st.res               <= '0;
			st.base_write_fault  <= 1'b0;
			st.base_write_done   <= 1'b0;
			st.model_reg_rdata   <= '0;
			st.model_reg_rvalid  <= 1'b0;
			st.sel_read_data     <= SRU_SEL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops; code attributes honoured in any mode
	assign ref_res           = st.res;
	assign current_privilege = st.current_privilege;
	assign wide_mode         = st.seg[SRU_SEG_CODE].hidden.wide_mode;
	assign op_size           = st.seg[SRU_SEG_CODE].hidden.op_size;
	assign base_write_fault  = st.base_write_fault;
	assign base_write_done   = st.base_write_done;
	assign model_reg_rdata   = st.model_reg_rdata;
	assign model_reg_rvalid  = st.model_reg_rvalid;
	assign sel_read_data     = st.sel_read_data;
endmodule : sru_top
`default_nettype wire

// ### sru_top_assertions.sv
// concurrent checks on the segment register unit ports
`default_nettype none
module sru_top_assertions
	import sru_pkg::*;
(
	// clock and reset
	input wire logic         clk_sys,
	input wire logic         resetn,
	// stimulus side
	input wire logic         long_64,
	input wire logic         user_base_write_enable,
	input wire logic         load_valid,
	input wire logic [2:0]   load_seg,
	input wire logic [15:0]  load_selector,
	input wire sru_desc_s    load_desc,
	input wire logic         model_reg_write_insn,
	input wire logic [31:0]  model_reg_addr,
	input wire logic [63:0]  model_reg_data,
	input wire logic         write_aux_one_base_insn,
	input wire logic         write_aux_two_base_insn,
	input wire logic         base_op_32,
	input wire logic [63:0]  base_wr_data,
	input wire logic [2:0]   sel_read_seg,
	input wire sru_ref_s     ref_req,
	// results
	input wire sru_res_s     ref_res,
	input wire logic [1:0]   current_privilege,
	input wire logic         base_write_fault,
	input wire logic         base_write_done,
	input wire logic [15:0]  sel_read_data
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// a load, then a read of that register while no load is pending
	sequence s_load_read;
		load_valid ##1 (sel_read_seg == $past(load_seg) && !load_valid);
	endsequence
	// model write that the unit must take
	sequence s_msr_ok;
		model_reg_write_insn && current_privilege == 2'h0 && sru_is_canonical(model_reg_data) &&
			(model_reg_addr == SRU_MSR_AUX_ONE || model_reg_addr == SRU_MSR_AUX_TWO);
	endsequence
	a_sel_read: assert property (s_load_read |=> sel_read_data == $past(load_selector, 2))
		else $error("selector readback differs from loaded value");
	a_code_priv: assert property (load_valid && load_seg == SRU_SEG_CODE |=>
		current_privilege == $past(load_desc.descriptor_privilege)) else $error("privilege not from code load");
	a_priv_hold: assert property (!(load_valid && load_seg == SRU_SEG_CODE) |=> $stable(current_privilege))
		else $error("privilege moved without code load");
	a_fetch_code: assert property (ref_req.valid && ref_req.kind == SRU_REF_FETCH |=>
		ref_res.valid && ref_res.segment == SRU_SEG_CODE) else $error("fetch not on code segment");
	a_string_extra: assert property (ref_req.valid && ref_req.kind == SRU_REF_STRING_DST |=>
		ref_res.valid && ref_res.segment == SRU_SEG_EXTRA) else $error("string target not on extra segment");
	a_stack_seg: assert property (ref_req.valid && ref_req.kind == SRU_REF_STACK |=>
		ref_res.valid && ref_res.segment == SRU_SEG_STACK) else $error("stack access not on stack segment");
	a_msr_write: assert property (s_msr_ok |=> base_write_done && !base_write_fault)
		else $error("model base write not taken");
	a_msr_denied: assert property (model_reg_write_insn && current_privilege != 2'h0 &&
		!write_aux_one_base_insn && !write_aux_two_base_insn |=> !base_write_done && !base_write_fault)
		else $error("unprivileged model write answered");
	a_bad_base: assert property ((write_aux_one_base_insn || write_aux_two_base_insn) &&
		user_base_write_enable && long_64 && !base_op_32 && !model_reg_write_insn &&
		!sru_is_canonical(base_wr_data) |=> base_write_fault && !base_write_done) else $error("no fault");
	a_user_off: assert property ((write_aux_one_base_insn || write_aux_two_base_insn) &&
		!(user_base_write_enable && long_64) && !model_reg_write_insn |=> !base_write_done && !base_write_fault)
		else $error("disabled user base write answered");
endmodule : sru_top_assertions
bind sru_top sru_top_assertions sru_top_assertions_i (.clk_sys, .resetn, .long_64, .user_base_write_enable,
	.load_valid, .load_seg, .load_selector, .load_desc, .model_reg_write_insn, .model_reg_addr, .model_reg_data,
	.write_aux_one_base_insn, .write_aux_two_base_insn, .base_op_32, .base_wr_data, .sel_read_seg, .ref_req,
	.ref_res, .current_privilege, .base_write_fault, .base_write_done, .sel_read_data);
`default_nettype wire

// ### sru_top_bench.sv
// self-checking bench for the segment register unit
`default_nettype none
module sru_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import sru_pkg::*;
	logic        clk_sys, resetn, long_64, user_base_write_enable, load_valid, base_op_32;
	logic        model_reg_write_insn, write_aux_one_base_insn, write_aux_two_base_insn, model_reg_read_insn;
	logic        wide_mode, op_size, base_write_fault, base_write_done, model_reg_rvalid;
	logic [2:0]  load_seg, sel_read_seg;
	logic [15:0] load_selector, sel_read_data;
	logic [31:0] model_reg_addr;
	logic [63:0] model_reg_data, base_wr_data, model_reg_rdata;
	logic [1:0]  current_privilege;
	sru_desc_s   load_desc;
	sru_ref_s    ref_req;
	sru_res_s    ref_res;
	logic [63:0] base [6] = '{default: '0};
	logic [15:0] sel [6] = '{default: '0};
	int          num_errors = 0, num_checks = 0, cycles = 0;

	sru_top sru_top_i (.clk_sys, .resetn, .long_64, .user_base_write_enable, .load_valid, .load_seg,
		.load_selector, .load_desc, .model_reg_write_insn, .model_reg_addr, .model_reg_data,
		.write_aux_one_base_insn, .write_aux_two_base_insn, .base_op_32, .base_wr_data, .model_reg_read_insn,
		.sel_read_seg, .ref_req, .ref_res, .current_privilege, .wide_mode, .op_size, .base_write_fault,
		.base_write_done, .model_reg_rdata, .model_reg_rvalid, .sel_read_data);

	// 25 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 3000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic bit canon(input logic [63:0] a);
		return a[63:47] == '0 || a[63:47] == '1;
	endfunction : canon

	function automatic logic [63:0] rcanon();
		logic [63:0] r;
		r = {$urandom, $urandom};
		return {{17{r[46]}}, r[46:0]};
	endfunction : rcanon

	// pulses drop one full cycle before the next request is raised
	task automatic idle();
		{load_valid, model_reg_write_insn, write_aux_one_base_insn, write_aux_two_base_insn} = '0;
		{model_reg_read_insn, ref_req.valid} = '0;
		@(negedge clk_sys);
	endtask : idle

	task automatic load(input logic [2:0] s, input logic [15:0] v, input logic [63:0] bs, input logic [1:0] p);
		load_valid = 1'b1;
		load_seg = s;
		sel_read_seg = s;
		load_selector = v;
		load_desc = '{base: bs, limit: 32'hFFFFFFFF, descriptor_privilege: p, wide_mode: !p[1], op_size: p[0],
			present: 1'b1};
		@(negedge clk_sys);
		if (s == SRU_SEG_CODE) check("privilege", p, current_privilege);
		// code attributes follow the loaded descriptor; privilege bits vary them so a stuck flop shows
		if (s == SRU_SEG_CODE) check("wide mode", !p[1], wide_mode);
		if (s == SRU_SEG_CODE) check("op size", p[0], op_size);
		sel[s] = v;
		if (!(s > 3 && v[15:2] == '0)) base[s] = s > 3 ? {32'h0, bs[31:0]} : bs;
		idle();
	endtask : load

	task automatic rd_sel(input logic [2:0] s, input logic [15:0] e);
		sel_read_seg = s;
		@(negedge clk_sys);
		check("selector", e, sel_read_data);
	endtask : rd_sel

	task automatic rd_base(input bit t);
		model_reg_read_insn = 1'b1;
		model_reg_addr = t ? SRU_MSR_AUX_TWO : SRU_MSR_AUX_ONE;
		@(negedge clk_sys);
		check("read valid", 1, model_reg_rvalid);
		check("aux base", base[4 + t], model_reg_rdata);
		idle();
	endtask : rd_base

	// usr selects the user instruction path, t the second auxiliary base
	task automatic wr(input bit usr, input bit t, input logic [63:0] v, input logic ok, input logic flt);
		if (usr) begin
			write_aux_one_base_insn = !t;
			write_aux_two_base_insn = t;
			base_wr_data = v;
		end else begin
			model_reg_write_insn = 1'b1;
			model_reg_addr = t ? SRU_MSR_AUX_TWO : SRU_MSR_AUX_ONE;
			model_reg_data = v;
		end
		@(negedge clk_sys);
		check("write done", ok, base_write_done);
		check("write fault", flt, base_write_fault);
		if (ok) base[4 + t] = (usr && base_op_32) ? {32'h0, v[31:0]} : v;
		idle();
	endtask : wr

	task automatic rf(input sru_ref_e k);
		logic [2:0]  s;
		logic [63:0] e;
		logic [63:0] l;
		ref_req.valid = 1'b1;
		ref_req.kind = k;
		ref_req.override_en = 1'($urandom);
		ref_req.override_seg = 3'($urandom_range(5));
		ref_req.base_reg = {$urandom_range(1) ? 32'h80000000 : 32'h0, 32'($urandom)};
		ref_req.index_reg = 64'($urandom_range(65535));
		ref_req.scale_log2 = 2'($urandom);
		ref_req.displacement = 64'(signed'(32'($urandom)));
		s = k == SRU_REF_FETCH ? SRU_SEG_CODE : k == SRU_REF_STACK ? SRU_SEG_STACK :
			k == SRU_REF_STRING_DST ? SRU_SEG_EXTRA : ref_req.override_en ? ref_req.override_seg : SRU_SEG_DATA;
		e = ref_req.base_reg + (ref_req.index_reg << ref_req.scale_log2) + ref_req.displacement;
		l = long_64 ? (s > 3 ? base[s] + e : e) : {32'h0, base[s][31:0] + e[31:0]};
		@(negedge clk_sys);
		check("ref valid", 1, ref_res.valid);
		check("segment", s, ref_res.segment);
		check("effective", e, ref_res.effective_addr);
		check("linear", l, ref_res.linear_addr);
		check("fault", long_64 ? !canon(l) : sel[s][15:2] == '0, ref_res.protection_fault);
		idle();
	endtask : rf

	// main sequence
	initial begin
		{long_64, user_base_write_enable, load_valid, load_seg, load_selector, load_desc, model_reg_addr} = '0;
		{model_reg_write_insn, model_reg_data, write_aux_one_base_insn, write_aux_two_base_insn} = '0;
		{base_op_32, base_wr_data, model_reg_read_insn, sel_read_seg, ref_req} = '0;
		resetn = 1'b0;
		void'($urandom(76869));
		repeat (12) @(negedge clk_sys);
		resetn = 1'b1;
		for (int s = 0; s < 7; s++) rd_sel(3'(s), 16'h0000);
		rd_base(0);
		for (int s = 0; s < 6; s++) load(3'(s), {13'($urandom_range(8191, 1)), 3'($urandom)}, {$urandom, $urandom},
			2'($urandom));
		load(SRU_SEG_CODE, 16'h0008, {$urandom, $urandom}, 2'h0);
		for (int s = 0; s < 6; s++) rd_sel(3'(s), sel[s]);
		rd_base(0);
		rd_base(1);
		load(SRU_SEG_AUX_ONE, {14'h0000, 2'($urandom)}, {$urandom, $urandom}, 2'h0);
		rd_base(0);
		for (int n = 0; n < 4; n++) begin
			wr(0, n[0], rcanon(), 1'b1, 1'b0);
			wr(0, n[0], rcanon() ^ 64'h8000000000000000, 1'b0, 1'b1);
			rd_base(n[0]);
		end
		long_64 = 1'b1;
		user_base_write_enable = 1'b1;
		for (int n = 0; n < 4; n++) begin
			base_op_32 = n[1];
			wr(1, n[0], n[1] ? {$urandom, $urandom} : rcanon(), 1'b1, 1'b0);
			wr(1, n[0], rcanon() ^ 64'h8000000000000000, n[1], !n[1]);
			rd_base(n[0]);
		end
		load(SRU_SEG_CODE, 16'h0013, {$urandom, $urandom}, 2'h3);
		wr(0, 1, rcanon(), 1'b0, 1'b0);
		wr(1, 1, rcanon(), 1'b1, 1'b0);
		load(SRU_SEG_CODE, 16'h0008, {$urandom, $urandom}, 2'h0);
		rd_base(1);
		user_base_write_enable = 1'b0;
		wr(1, 0, rcanon(), 1'b0, 1'b0);
		user_base_write_enable = 1'b1;
		long_64 = 1'b0;
		wr(1, 1, rcanon(), 1'b0, 1'b0);
		// mode flips between references must not disturb any register
		for (int n = 0; n < 64; n++) begin
			long_64 = n[0];
			rf(sru_ref_e'(n[2:1]));
		end
		for (int s = 0; s < 6; s++) rd_sel(3'(s), sel[s]);
		print_verdict();
	end
endmodule : sru_top_bench
`default_nettype wire
